// file: hdl/bir_irq_router.v
// Implementation choices: the register offsets and the strobed register port.
`include "bir_defines.vh"

// Functional notes
// - fifteen legacy requests are served as a primary and secondary controller pair.
// - each line can be set edge or level mode except lines 0, 1, 2, 8 and 13.
// - four pci inputs each have a route register selecting one of eleven legacy lines.
// - several pci inputs may be routed onto the same legacy line at once.
// - after reset every legacy line is in edge mode.
// - line 0 comes from the internal timer as an active-high edge source.
// - priority is line 0, line 1, secondary lines 8 to 15, then lines 3 to 7.
// - the multiprocessor controller serves two processors and sixteen external inputs.
// - it also holds two cross-processor sources and one timer source.
// - the legacy output drives multiprocessor input 0 as an active-high level.
module bir_irq_router #(
    parameter NUM_CPU = 2,
    parameter NUM_EXT = 16
) (
    // clock, enable, reset
    input wire mclk,
    input wire clk_en,
    input wire reset,
    // register port
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    // legacy request pins, bit n is line n (0 and 2 unused here)
    input wire [15:0] isa_irq_in,
    // active-low pci_irq_inputs
    input wire [3:0] pci_irq_inputs_n,
    // internal timer channel level
    input wire timer_tick,
    // board sources for the multiprocessor side, active low
    input wire [NUM_EXT-1:0] mp_ext_n,
    // controller outputs
    output reg legacy_int_reg,
    output reg [NUM_CPU-1:0] cpu_int_reg,
    output reg irq_reg
);
    // synchronise pins
    reg [15:0] isa_s1, isa_s2;
    reg [3:0] pci_s1, pci_s2;
    reg [NUM_EXT-1:0] mp_s1, mp_s2;
    always @(posedge mclk) begin
        if (reset) begin
            isa_s1 <= 16'h0000;
            isa_s2 <= 16'h0000;
            pci_s1 <= 4'hF;
            pci_s2 <= 4'hF;
            mp_s1 <= {NUM_EXT{1'b1}};
            mp_s2 <= {NUM_EXT{1'b1}};
        end else if (clk_en) begin
            isa_s1 <= isa_irq_in;
            isa_s2 <= isa_s1;
            pci_s1 <= pci_irq_inputs_n;
            pci_s2 <= pci_s1;
            mp_s1 <= mp_ext_n;
            mp_s2 <= mp_s1;
        end
    end

    // control registers
    reg [15:0] edge_level_control_register_reg;
    reg [7:0] route_reg [0:3];
    reg [15:0] irr_reg, isr_reg, prev_reg;
    reg [3:0] vec_reg;
    reg [NUM_EXT-1:0] mp_en_reg;
    reg [3:0] mp_tmr_reg;
    reg [`BIR_EV_W-1:0] stat_reg, en_reg;
    reg tmr_prev;

    // a route target is legal when not one of the reserved lines
    function legal_target;
        input [3:0] ln;
        reg [15:0] free_lines;
        begin
            // pick one bit on purpose rather than truncating a shift
            free_lines = ~`BIR_FIXED_LINES;
            legal_target = free_lines[ln];
        end
    endfunction

    // combine routed pci inputs onto legacy lines
    // or of routes
    integer r;
    reg [15:0] pci_lines;
    reg [3:0] tgt;
    always @* begin
        pci_lines = 16'h0000;
        tgt = 4'h0;
        for (r = 0; r < 4; r = r + 1) begin
            tgt = route_reg[r][`BIR_ROUTE_LINE_MSB:0];
            if (!route_reg[r][`BIR_ROUTE_DIS_BIT] && legal_target(tgt)
                    && !pci_s2[r])
                pci_lines[tgt] = 1'b1;
        end
    end

    // assemble raw requests; line 2 is the cascade and carries nothing
    reg [15:0] raw;
    always @* begin
        raw = (isa_s2 | pci_lines) & 16'hFFFA;
        raw[0] = timer_tick;
    end

    // edge mode latches rising edges; level mode follows the pin
    wire [15:0] rise = raw & ~prev_reg;
    wire [15:0] lvl_mask = edge_level_control_register_reg & ~`BIR_FIXED_LINES;
    wire [15:0] irr_next = (irr_reg & ~lvl_mask) | (rise & ~lvl_mask)
        | (raw & lvl_mask);

    // pending lines that are not themselves in service
    wire [3:0] best;
    wire any_pend;
    bir_prio u_prio (
        .pend(irr_reg & ~isr_reg),
        .line(best),
        .any(any_pend)
    );
    wire in_service = |isr_reg;

    wire wr_eoi = reg_wr && reg_addr == `BIR_OFF_EOI;
    wire ack = any_pend && !in_service;

    // legacy controller state
    always @(posedge mclk) begin
        if (reset) begin
            irr_reg <= 16'h0000;
            isr_reg <= 16'h0000;
            prev_reg <= 16'h0000;
            vec_reg <= 4'h0;
            tmr_prev <= 1'b0;
        end else if (clk_en) begin
            prev_reg <= raw;
            tmr_prev <= timer_tick;
            // accept one request at a time; eoi retires it
            if (ack) begin
                isr_reg <= 16'h0001 << best;
                vec_reg <= best;
                irr_reg <= irr_next & ~(16'h0001 << best);
            end else begin
                irr_reg <= irr_next;
                if (wr_eoi)
                    isr_reg <= 16'h0000;
            end
        end
    end

    // registers written by software
    integer k;
    always @(posedge mclk) begin
        if (reset) begin
            edge_level_control_register_reg <= `BIR_EDGE_LEVEL_CONTROL_REGISTER_RST;
            for (k = 0; k < 4; k = k + 1)
                route_reg[k] <= `BIR_ROUTE_RST;
            mp_en_reg <= {NUM_EXT{1'b0}};
            en_reg <= {`BIR_EV_W{1'b0}};
        end else if (clk_en && reg_wr) begin
            case (reg_addr)
                `BIR_OFF_EDGE_LEVEL_CONTROL_REGISTER: edge_level_control_register_reg <= reg_wdata[15:0]
                    & ~`BIR_FIXED_LINES;
                `BIR_OFF_ROUTE0: route_reg[0] <= reg_wdata[7:0];
                `BIR_OFF_ROUTE1: route_reg[1] <= reg_wdata[7:0];
                `BIR_OFF_ROUTE2: route_reg[2] <= reg_wdata[7:0];
                `BIR_OFF_ROUTE3: route_reg[3] <= reg_wdata[7:0];
                `BIR_OFF_MP_CTL: mp_en_reg <= reg_wdata[NUM_EXT-1:0];
                `BIR_OFF_INT_EN: en_reg <= reg_wdata[`BIR_EV_W-1:0];
                default: ;
            endcase
        end
    end

    // multiprocessor side: input 0 is the legacy output, high level
    // legacy into input 0
    wire [NUM_EXT-1:0] mp_raw = {~mp_s2[NUM_EXT-1:1], legacy_int_reg};
    wire mp_any = |(mp_raw & mp_en_reg);
    wire ipi0_wr = reg_wr && reg_addr == `BIR_OFF_MP_RAW
        && reg_wdata[0];
    wire ipi1_wr = reg_wr && reg_addr == `BIR_OFF_MP_RAW
        && reg_wdata[1];
    wire tmr_ev = timer_tick && !tmr_prev;
    wire leg_ev = ack;
    wire [`BIR_EV_W-1:0] ev = {tmr_ev, ipi1_wr, ipi0_wr, leg_ev};
    wire clr_wr = reg_wr && reg_addr == `BIR_OFF_INT_CLR;

    // status, outputs; a set in the clear cycle wins
    always @(posedge mclk) begin
        if (reset) begin
            stat_reg <= {`BIR_EV_W{1'b0}};
            mp_tmr_reg <= 4'h0;
            legacy_int_reg <= 1'b0;
            cpu_int_reg <= {NUM_CPU{1'b0}};
            irq_reg <= 1'b0;
        end else if (clk_en) begin
            stat_reg <= (stat_reg & ~(clr_wr ? reg_wdata[`BIR_EV_W-1:0]
                : {`BIR_EV_W{1'b0}})) | ev;
            mp_tmr_reg <= mp_tmr_reg + {3'b000, tmr_ev};
            legacy_int_reg <= in_service;
            cpu_int_reg[0] <= mp_any | stat_reg[`BIR_EV_IPI0]
                | stat_reg[`BIR_EV_TMR];
            cpu_int_reg[NUM_CPU-1] <= mp_any | stat_reg[`BIR_EV_IPI1]
                | stat_reg[`BIR_EV_TMR];
            irq_reg <= |(stat_reg & en_reg);
        end
    end

    // read port, one cycle latency; unmapped reads give zero
    always @(posedge mclk) begin
        if (reset) begin
            reg_rdata <= 32'h0000_0000;
        end else if (clk_en) begin
            reg_rdata <= 32'h0000_0000;
            if (reg_rd) begin
                case (reg_addr)
                    `BIR_OFF_EDGE_LEVEL_CONTROL_REGISTER: reg_rdata <= {16'h0000, edge_level_control_register_reg};
                    `BIR_OFF_ROUTE0: reg_rdata <= {24'h00_0000, route_reg[0]};
                    `BIR_OFF_ROUTE1: reg_rdata <= {24'h00_0000, route_reg[1]};
                    `BIR_OFF_ROUTE2: reg_rdata <= {24'h00_0000, route_reg[2]};
                    `BIR_OFF_ROUTE3: reg_rdata <= {24'h00_0000, route_reg[3]};
                    `BIR_OFF_LEG_STAT: reg_rdata <= {isr_reg, irr_reg};
                    `BIR_OFF_LEG_VEC: reg_rdata <= {27'h000_0000,
                        in_service, vec_reg};
                    `BIR_OFF_MP_RAW: reg_rdata <= {16'h0000, mp_raw};
                    `BIR_OFF_MP_CTL: reg_rdata <= {16'h0000, mp_en_reg};
                    `BIR_OFF_INT_STAT: reg_rdata <= {28'h000_0000, stat_reg};
                    `BIR_OFF_INT_EN: reg_rdata <= {28'h000_0000, en_reg};
                    default: reg_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule // bir_irq_router

// file: hdl/bir_defines.vh
`ifndef BIR_DEFINES_VH
`define BIR_DEFINES_VH
// register offsets (byte addresses, one 32-bit word each)
`define BIR_OFF_EDGE_LEVEL_CONTROL_REGISTER 8'h00
`define BIR_OFF_ROUTE0 8'h04
`define BIR_OFF_ROUTE1 8'h08
`define BIR_OFF_ROUTE2 8'h0C
`define BIR_OFF_ROUTE3 8'h10
`define BIR_OFF_LEG_STAT 8'h14
`define BIR_OFF_LEG_VEC 8'h18
`define BIR_OFF_EOI 8'h1C
`define BIR_OFF_MP_RAW 8'h20
`define BIR_OFF_MP_CTL 8'h24
`define BIR_OFF_INT_STAT 8'h28
`define BIR_OFF_INT_EN 8'h2C
`define BIR_OFF_INT_CLR 8'h30
// reset values
`define BIR_EDGE_LEVEL_CONTROL_REGISTER_RST 16'h0000
`define BIR_ROUTE_RST 8'h80
// route register fields
`define BIR_ROUTE_DIS_BIT 7
`define BIR_ROUTE_LINE_MSB 3
// lines that may never be level-mode or routed targets
`define BIR_FIXED_LINES 16'h2107
`define BIR_CASCADE_LINE 2
// interrupt status bit positions
`define BIR_EV_LEG 0
`define BIR_EV_IPI0 1
`define BIR_EV_IPI1 2
`define BIR_EV_TMR 3
`define BIR_EV_W 4
`endif

// file: hdl/bir_prio.v
// fixed legacy priority encoder: picks the most urgent pending line
module bir_prio (
    // pending lines, one bit per legacy line
    input wire [15:0] pend,
    // chosen line and whether anything is pending
    output reg [3:0] line,
    output reg any
);
    // order table: 0,1, then secondary 8..15, then 3..7
    function [3:0] slot_line;
        input [3:0] s;
        begin
            if (s < 4'h2)
                slot_line = s;
            else if (s < 4'hA)
                slot_line = s + 4'h6;
            else
                slot_line = s - 4'h7;
        end
    endfunction

    integer i;
    reg [3:0] cand;
    // scan from lowest urgency upward so the most urgent overwrites
    always @* begin
        line = 4'h0;
        any = 1'b0;
        cand = 4'h0;
        for (i = 14; i >= 0; i = i - 1) begin
            cand = slot_line(i[3:0]);
            if (pend[cand]) begin
                line = cand;
                any = 1'b1;
            end
        end
    end
endmodule // bir_prio

// file: testbench/bir_checker.sv
// watches the router ports; writes to the edge level and route registers since reset are tracked
module bir_checker #(
    parameter NUM_CPU = 2,
    parameter NUM_EXT = 16
) (
    // clock, enable, reset
    input wire mclk,
    input wire clk_en,
    input wire reset,
    // register port
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [31:0] reg_rdata,
    // request pins and outputs
    input wire [15:0] isa_irq_in,
    input wire [3:0] pci_irq_inputs_n,
    input wire timer_tick,
    input wire [NUM_EXT-1:0] mp_ext_n,
    input wire legacy_int_reg,
    input wire [NUM_CPU-1:0] cpu_int_reg,
    input wire irq_reg
);
    timeunit 1ns;
    timeprecision 1ps;
    reg edge_level_control_register_w_reg;
    reg route_w_reg;
    wire route_hit = reg_addr >= 8'h04 && reg_addr <= 8'h10;
    wire eoi_wr = reg_wr && reg_addr == 8'h1C;
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    // reset values only hold until software first writes the register
    always @(posedge mclk) begin
        if (reset) begin
            edge_level_control_register_w_reg <= 1'b0;
            route_w_reg <= 1'b0;
        end else if (reg_wr) begin
            edge_level_control_register_w_reg <= edge_level_control_register_w_reg | (reg_addr == 8'h00);
            route_w_reg <= route_w_reg | route_hit;
        end
    end
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 0)
        else $error("read data not zero outside a read");
    a_reset_quiet: assert property ($past(reset) |->
        !legacy_int_reg && cpu_int_reg == 0 && !irq_reg)
        else $error("output active right after reset");
    a_edge_level_control_register_fixed: assert property (
        $past(reg_rd && reg_addr == 8'h00) |->
        (reg_rdata & 32'hFFFF_2107) == 0)
        else $error("fixed line shows level mode");
    a_edge_level_control_register_reset: assert property (
        $past(reg_rd && reg_addr == 8'h00 && !edge_level_control_register_w_reg) |-> reg_rdata == 0)
        else $error("line not edge mode after reset");
    a_route_reset: assert property (
        $past(reg_rd && route_hit && !route_w_reg) |-> reg_rdata == 32'h80)
        else $error("route register not disabled after reset");
    a_unmapped_zero: assert property (
        $past(reg_rd && reg_addr > 8'h30) |-> reg_rdata == 0)
        else $error("unmapped read not zero");
    a_timer_edge: assert property (
        $rose(timer_tick) && !legacy_int_reg |-> ##[1:8] legacy_int_reg)
        else $error("timer edge not served");
    a_legacy_hold: assert property (
        legacy_int_reg && !eoi_wr && !$past(eoi_wr) |=> legacy_int_reg)
        else $error("service ended without end of interrupt");
    a_irq_mask: assert property (
        reg_wr && reg_addr == 8'h2C && reg_wdata[3:0] == 0 |->
        ##[1:2] !irq_reg)
        else $error("irq high with all sources masked");
    c_legacy: cover property ($rose(legacy_int_reg));
    c_irq: cover property ($rose(irq_reg));
    c_eoi: cover property (eoi_wr && legacy_int_reg);
endmodule // bir_checker

// file: testbench/bir_src_model.sv
// board request sources; pins change just after a rising edge
module bir_src_model (
    // clock
    input wire mclk,
    // requests from the bench, active high
    input wire [15:0] isa_req,
    input wire [3:0] pci_req,
    input wire tmr_req,
    // pins toward the router
    output reg [15:0] isa_irq_in,
    output reg [3:0] pci_irq_inputs_n,
    output reg timer_tick,
    output reg [15:0] mp_ext_n
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        isa_irq_in = 16'h0000;
        pci_irq_inputs_n = 4'hF;
        timer_tick = 1'b0;
        mp_ext_n = 16'hFFFF;
    end
    // active levels
    // pci lines are level and active low; each also reaches the mp side
    always @(posedge mclk) begin
        isa_irq_in <= isa_req;
        timer_tick <= tmr_req;
        pci_irq_inputs_n <= ~pci_req;
        mp_ext_n <= ~{11'h000, pci_req, 1'b0};
    end
endmodule // bir_src_model

// file: testbench/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    reg mclk = 1'b0;
    reg reset = 1'b1;
    reg [7:0] reg_addr = 8'h00;
    reg [31:0] reg_wdata = 32'h0000_0000;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg [15:0] isa_req = 16'h0000;
    reg [3:0] pci_req = 4'h0;
    reg tmr_req = 1'b0;
    wire [31:0] reg_rdata;
    wire [15:0] isa_irq_in;
    wire [3:0] pci_irq_inputs_n;
    wire timer_tick;
    wire [15:0] mp_ext_n;
    wire legacy_int_reg;
    wire [1:0] cpu_int_reg;
    wire irq_reg;
    int miscompares = 0;
    int n_checks = 0;
    int i;
    always #20 mclk = ~mclk;
    bir_src_model src (.mclk(mclk), .isa_req(isa_req), .pci_req(pci_req),
        .tmr_req(tmr_req), .isa_irq_in(isa_irq_in),
        .pci_irq_inputs_n(pci_irq_inputs_n), .timer_tick(timer_tick),
        .mp_ext_n(mp_ext_n));
    bir_irq_router #(.NUM_CPU(2), .NUM_EXT(16)) uut (.mclk(mclk),
        .clk_en(1'b1), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .isa_irq_in(isa_irq_in),
        .pci_irq_inputs_n(pci_irq_inputs_n), .timer_tick(timer_tick),
        .mp_ext_n(mp_ext_n), .legacy_int_reg(legacy_int_reg),
        .cpu_int_reg(cpu_int_reg), .irq_reg(irq_reg));
    task chk(input string what, input [31:0] exp, input [31:0] got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task stop_test();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task wr(input [7:0] a, input [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task rd(input [7:0] a, input [31:0] exp, input string what);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        chk(what, exp, reg_rdata);
    endtask
    // bounded wait on the legacy output; a hang ends the run
    task wait_leg(input bit lvl);
        for (i = 0; i < 20 && legacy_int_reg !== lvl; i++)
            @(negedge mclk);
        chk("legacy_int_reg", lvl, legacy_int_reg);
        if (legacy_int_reg !== lvl)
            stop_test();
    endtask
    initial begin
        repeat (20) @(posedge mclk);
        reset <= 1'b0;
        @(negedge mclk);
        chk("outputs", 0, {legacy_int_reg, cpu_int_reg, irq_reg});
        // defaults, fixed lines, unmapped and read-only places
        rd(8'h00, 32'h0, "edge_level_control_register reset");
        for (int r = 1; r < 5; r++)
            rd(8'(4 * r), 32'h80, "route reset");
        wr(8'h00, 32'hFFFF_FFFF);
        rd(8'h00, 32'h0000_DEF8, "edge_level_control_register fixed");
        wr(8'h40, 32'h1234_5678);
        rd(8'h40, 32'h0, "unmapped");
        wr(8'h28, 32'hF);
        rd(8'h28, 32'h0, "status read only");
        $display("test registers done");
        // both cross-processor events, then mask and clear
        wr(8'h30, 32'hF);
        wr(8'h20, 32'h3);
        wr(8'h20, 32'h0);
        rd(8'h28, 32'h6, "ipi status");
        wr(8'h2C, 32'h6);
        repeat (3) @(negedge mclk);
        chk("irq enabled", 1, irq_reg);
        wr(8'h2C, 32'h0);
        repeat (3) @(negedge mclk);
        chk("irq masked", 0, irq_reg);
        wr(8'h2C, 32'h6);
        wr(8'h30, 32'h6);
        repeat (3) @(negedge mclk);
        chk("irq cleared", 0, irq_reg);
        rd(8'h28, 32'h0, "status cleared");
        $display("test interrupts done");
        // two pci inputs share line 10, set to level by software
        wr(8'h00, 32'h0400);
        wr(8'h24, 32'h1);
        wr(8'h04, 32'h0A);
        wr(8'h08, 32'h0A);
        @(posedge mclk) pci_req <= 4'h2;
        wait_leg(1);
        rd(8'h18, 32'h1A, "vector pci");
        repeat (3) @(negedge mclk);
        chk("cpu request", 1, |cpu_int_reg);
        @(posedge mclk) pci_req <= 4'h1;
        wr(8'h1C, 32'h0);
        repeat (8) @(negedge mclk);
        rd(8'h18, 32'h1A, "vector shared");
        @(posedge mclk) pci_req <= 4'h0;
        // let the level drop through the synchroniser before retiring it
        repeat (5) @(negedge mclk);
        wr(8'h1C, 32'h0);
        wait_leg(0);
        wr(8'h0C, 32'h0D);
        @(posedge mclk) pci_req <= 4'h4;
        repeat (10) @(negedge mclk);
        chk("reserved route", 0, legacy_int_reg);
        @(posedge mclk) pci_req <= 4'h0;
        $display("test routing done");
        // timer, secondary line 9 and line 3 requested together
        @(posedge mclk) isa_req <= 16'h0208;
        tmr_req <= 1'b1;
        wait_leg(1);
        rd(8'h18, 32'h10, "vector timer");
        wr(8'h1C, 32'h0);
        repeat (8) @(negedge mclk);
        rd(8'h18, 32'h19, "vector secondary");
        wr(8'h1C, 32'h0);
        repeat (8) @(negedge mclk);
        rd(8'h18, 32'h13, "vector line 3");
        @(posedge mclk);
        isa_req <= 16'h0000;
        tmr_req <= 1'b0;
        wr(8'h1C, 32'h0);
        wait_leg(0);
        $display("test priority done");
        stop_test();
    end
endmodule // testbench
bind bir_irq_router bir_checker #(.NUM_CPU(NUM_CPU), .NUM_EXT(NUM_EXT)) chk (
    .mclk(mclk), .clk_en(clk_en), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .isa_irq_in(isa_irq_in),
    .pci_irq_inputs_n(pci_irq_inputs_n), .timer_tick(timer_tick),
    .mp_ext_n(mp_ext_n), .legacy_int_reg(legacy_int_reg),
    .cpu_int_reg(cpu_int_reg), .irq_reg(irq_reg));
